/* File: logic/gposeq_top.v */
// general output sequencing, pin configuration and serial register port
`timescale 1ns/1ns
`default_nettype none
`include "gposeq_defs.vh"

module gposeq_top #(
	parameter [13:0] TICK_CYCLES = `GPOSEQ_TICK_CYCLES,
	// device address is arbitrary
	parameter [6:0] DEV_ADDR = `GPOSEQ_DEV_ADDR
) (
	input wire ref_clk,
	input wire reset_n,
	input wire enable_pin,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	output reg first_general_output_out,
	output reg first_general_output_oe,
	output reg second_general_output_out,
	output reg second_general_output_oe,
	output reg external_clock_pin_select,
	output reg clock_pin_pulldown,
	output reg enable_pin_pulldown,
	output reg thermal_warning_threshold,
	output reg spread_spectrum_enable
);

	// ****************************************************************
	// serial port states
	// ****************************************************************
	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_ADDR = 4'h1;
	localparam [3:0] ST_ADDR_ACK = 4'h2;
	localparam [3:0] ST_PTR = 4'h3;
	localparam [3:0] ST_PTR_ACK = 4'h4;
	localparam [3:0] ST_WDATA = 4'h5;
	localparam [3:0] ST_WDATA_ACK = 4'h6;
	localparam [3:0] ST_RDATA = 4'h7;
	localparam [3:0] ST_RDATA_ACK = 4'h8;

	// ****************************************************************
	// registers and state
	// ****************************************************************
	reg [7:0] second_output_delay_reg;
	reg [7:0] output_control_reg;
	reg [7:0] device_config_reg;

	reg scl_meta_reg;
	reg scl_sync_reg;
	reg scl_prev_reg;
	reg sda_meta_reg;
	reg sda_sync_reg;
	reg sda_prev_reg;
	reg enable_meta_reg;
	reg enable_sync_reg;

	reg [3:0] state_reg;
	reg [3:0] bitcnt_reg;
	reg [7:0] shift_reg;
	reg [7:0] tx_reg;
	reg [7:0] ptr_reg;
	reg rw_reg;
	reg master_ack_reg;
	reg wr_stb_reg;
	reg [7:0] wr_addr_reg;
	reg [7:0] wr_data_reg;

	reg [7:0] read_data;

	wire scl_rise;
	wire scl_fall;
	wire start_cond;
	wire stop_cond;
	wire second_delayed;
	wire first_level;
	wire second_level;

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_meta_reg <= 1'b1;
			scl_sync_reg <= 1'b1;
			scl_prev_reg <= 1'b1;
			sda_meta_reg <= 1'b1;
			sda_sync_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			enable_meta_reg <= 1'b0;
			enable_sync_reg <= 1'b0;
		end else begin
			scl_meta_reg <= scl_in;
			scl_sync_reg <= scl_meta_reg;
			scl_prev_reg <= scl_sync_reg;
			sda_meta_reg <= sda_in;
			sda_sync_reg <= sda_meta_reg;
			sda_prev_reg <= sda_sync_reg;
			enable_meta_reg <= enable_pin;
			enable_sync_reg <= enable_meta_reg;
		end
	end

	assign scl_rise = scl_sync_reg & ~scl_prev_reg;
	assign scl_fall = ~scl_sync_reg & scl_prev_reg;
	// start and stop are data changes while the clock is high
	assign start_cond = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
	assign stop_cond = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

	// ****************************************************************
	// read multiplexer
	// ****************************************************************
	always @* begin
		case (ptr_reg)
			`GPOSEQ_OFF_SECOND_OUTPUT_DELAY: begin
				read_data = second_output_delay_reg;
			end
			`GPOSEQ_OFF_OUTPUT_CONTROL: begin
				read_data = output_control_reg & `GPOSEQ_OUTPUT_CONTROL_WMASK;
			end
			`GPOSEQ_OFF_DEVICE_CONFIG: begin
				read_data = device_config_reg;
			end
			default: begin
				read_data = 8'h00;
			end
		endcase
	end

	// ****************************************************************
	// serial port slave
	// ****************************************************************
	// sda is sampled on scl rise and changed on scl fall, so the
	// bus hold time is covered by the synchroniser latency
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			bitcnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= 8'h00;
			rw_reg <= 1'b0;
			master_ack_reg <= 1'b0;
			wr_stb_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 8'h00;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			sda_out <= 1'b0;
			wr_stb_reg <= 1'b0;
			if (start_cond) begin
				state_reg <= ST_ADDR;
				bitcnt_reg <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop_cond) begin
				state_reg <= ST_IDLE;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin
				case (state_reg)
					ST_ADDR, ST_PTR, ST_WDATA: begin
						shift_reg <= {shift_reg[6:0], sda_sync_reg};
						bitcnt_reg <= bitcnt_reg + 4'h1;
					end
					ST_RDATA_ACK: begin
						master_ack_reg <= ~sda_sync_reg;
					end
					default: begin
						bitcnt_reg <= bitcnt_reg;
					end
				endcase
			end else if (scl_fall) begin
				case (state_reg)
					ST_ADDR: begin
						if (bitcnt_reg == 4'h8) begin
							if (shift_reg[7:1] == DEV_ADDR) begin
								rw_reg <= shift_reg[0];
								sda_oe <= 1'b1;
								state_reg <= ST_ADDR_ACK;
							end else begin
								state_reg <= ST_IDLE;
							end
						end
					end
					ST_ADDR_ACK: begin
						if (rw_reg) begin
							tx_reg <= read_data;
							sda_oe <= ~read_data[7];
							bitcnt_reg <= 4'h1;
							state_reg <= ST_RDATA;
						end else begin
							sda_oe <= 1'b0;
							bitcnt_reg <= 4'h0;
							state_reg <= ST_PTR;
						end
					end
					ST_PTR: begin
						if (bitcnt_reg == 4'h8) begin
							ptr_reg <= shift_reg;
							sda_oe <= 1'b1;
							state_reg <= ST_PTR_ACK;
						end
					end
					ST_PTR_ACK, ST_WDATA_ACK: begin
						sda_oe <= 1'b0;
						bitcnt_reg <= 4'h0;
						state_reg <= ST_WDATA;
					end
					ST_WDATA: begin
						if (bitcnt_reg == 4'h8) begin
							wr_stb_reg <= 1'b1;
							wr_addr_reg <= ptr_reg;
							wr_data_reg <= shift_reg;
							ptr_reg <= ptr_reg + 8'h01;
							sda_oe <= 1'b1;
							state_reg <= ST_WDATA_ACK;
						end
					end
					ST_RDATA: begin
						if (bitcnt_reg == 4'h8) begin
							// release the line for the master's acknowledge
							sda_oe <= 1'b0;
							ptr_reg <= ptr_reg + 8'h01;
							state_reg <= ST_RDATA_ACK;
						end else begin
							sda_oe <= ~tx_reg[6];
							tx_reg <= {tx_reg[6:0], 1'b0};
							bitcnt_reg <= bitcnt_reg + 4'h1;
						end
					end
					ST_RDATA_ACK: begin
						if (master_ack_reg) begin
							tx_reg <= read_data;
							sda_oe <= ~read_data[7];
							bitcnt_reg <= 4'h1;
							state_reg <= ST_RDATA;
						end else begin
							sda_oe <= 1'b0;
							state_reg <= ST_IDLE;
						end
					end
					default: begin
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// register file
	// ****************************************************************
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			second_output_delay_reg <= `GPOSEQ_RST_SECOND_OUTPUT_DELAY;
			output_control_reg <= `GPOSEQ_RST_OUTPUT_CONTROL;
			device_config_reg <= `GPOSEQ_RST_DEVICE_CONFIG;
		end else if (wr_stb_reg) begin
			case (wr_addr_reg)
				`GPOSEQ_OFF_SECOND_OUTPUT_DELAY: begin
					second_output_delay_reg <= wr_data_reg;
				end
				`GPOSEQ_OFF_OUTPUT_CONTROL: begin
					// reserved bits 7 and 3 are read-only zero
					output_control_reg <= wr_data_reg & `GPOSEQ_OUTPUT_CONTROL_WMASK;
				end
				`GPOSEQ_OFF_DEVICE_CONFIG: begin
					device_config_reg <= wr_data_reg;
				end
				default: begin
					device_config_reg <= device_config_reg;
				end
			endcase
		end
	end

	// ****************************************************************
	// second output delay timer
	// ****************************************************************
	gposeq_delay #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_delay (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.enable_level(enable_sync_reg),
		.on_code(second_output_delay_reg[`GPOSEQ_ON_DELAY_MSB:`GPOSEQ_ON_DELAY_LSB]),
		.off_code(second_output_delay_reg[`GPOSEQ_OFF_DELAY_MSB:`GPOSEQ_OFF_DELAY_LSB]),
		.on_range(device_config_reg[`GPOSEQ_BIT_ON_RANGE]),
		.off_range(device_config_reg[`GPOSEQ_BIT_OFF_RANGE]),
		.delayed_level(second_delayed)
	);

	// ****************************************************************
	// output levels
	// ****************************************************************
	// the first output has no delay of its own here; it follows the
	// synchronised pin directly when pin follow is set
	assign first_level = output_control_reg[`GPOSEQ_BIT_FIRST_LEVEL] &
		(~output_control_reg[`GPOSEQ_BIT_FIRST_PIN_FOLLOW] | enable_sync_reg);
	assign second_level = output_control_reg[`GPOSEQ_BIT_SECOND_LEVEL] &
		(~output_control_reg[`GPOSEQ_BIT_SECOND_PIN_FOLLOW] | second_delayed);

	// ****************************************************************
	// pin drivers and configuration outputs
	// ****************************************************************
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			first_general_output_out <= 1'b0;
			first_general_output_oe <= 1'b0;
			second_general_output_out <= 1'b0;
			second_general_output_oe <= 1'b0;
			external_clock_pin_select <= 1'b0;
			clock_pin_pulldown <= 1'b0;
			enable_pin_pulldown <= 1'b0;
			thermal_warning_threshold <= 1'b0;
			spread_spectrum_enable <= 1'b0;
		end else begin
			if (output_control_reg[`GPOSEQ_BIT_FIRST_OPEN_DRAIN]) begin
				first_general_output_out <= 1'b0;
				first_general_output_oe <= ~first_level;
			end else begin
				first_general_output_out <= first_level;
				first_general_output_oe <= 1'b1;
			end
			if (device_config_reg[`GPOSEQ_BIT_CLOCK_PIN_FUNCTION]) begin
				// pin is the clock input, so never drive it
				second_general_output_out <= 1'b0;
				second_general_output_oe <= 1'b0;
			end else if (output_control_reg[`GPOSEQ_BIT_SECOND_OPEN_DRAIN]) begin
				second_general_output_out <= 1'b0;
				second_general_output_oe <= ~second_level;
			end else begin
				second_general_output_out <= second_level;
				second_general_output_oe <= 1'b1;
			end
			external_clock_pin_select <= device_config_reg[`GPOSEQ_BIT_CLOCK_PIN_FUNCTION];
			clock_pin_pulldown <= device_config_reg[`GPOSEQ_BIT_CLOCK_PIN_PULLDOWN];
			enable_pin_pulldown <= device_config_reg[`GPOSEQ_BIT_ENABLE_PIN_PULLDOWN];
			thermal_warning_threshold <= device_config_reg[`GPOSEQ_BIT_THERMAL_THRESHOLD];
			spread_spectrum_enable <= device_config_reg[`GPOSEQ_BIT_SPREAD_SPECTRUM];
		end
	end

endmodule
`default_nettype wire

/* File: logic/gposeq_defs.vh */
// constants for the general output sequencing and configuration block
`ifndef GPOSEQ_DEFS_VH
`define GPOSEQ_DEFS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define GPOSEQ_OFF_SECOND_OUTPUT_DELAY 8'h11
`define GPOSEQ_OFF_OUTPUT_CONTROL 8'h12
`define GPOSEQ_OFF_DEVICE_CONFIG 8'h13

// ****************************************************************
// reset values and output_control write mask
// ****************************************************************
`define GPOSEQ_RST_SECOND_OUTPUT_DELAY 8'h00
`define GPOSEQ_RST_OUTPUT_CONTROL 8'h00
`define GPOSEQ_RST_DEVICE_CONFIG 8'h00
`define GPOSEQ_OUTPUT_CONTROL_WMASK 8'h77

// ****************************************************************
// second_output_delay fields
// ****************************************************************
`define GPOSEQ_OFF_DELAY_MSB 7
`define GPOSEQ_OFF_DELAY_LSB 4
`define GPOSEQ_ON_DELAY_MSB 3
`define GPOSEQ_ON_DELAY_LSB 0

// ****************************************************************
// output_control fields
// ****************************************************************
`define GPOSEQ_BIT_SECOND_OPEN_DRAIN 6
`define GPOSEQ_BIT_SECOND_PIN_FOLLOW 5
`define GPOSEQ_BIT_SECOND_LEVEL 4
`define GPOSEQ_BIT_FIRST_OPEN_DRAIN 2
`define GPOSEQ_BIT_FIRST_PIN_FOLLOW 1
`define GPOSEQ_BIT_FIRST_LEVEL 0

// ****************************************************************
// device_config fields
// ****************************************************************
`define GPOSEQ_BIT_ON_RANGE 6
`define GPOSEQ_BIT_OFF_RANGE 5
`define GPOSEQ_BIT_CLOCK_PIN_FUNCTION 4
`define GPOSEQ_BIT_CLOCK_PIN_PULLDOWN 3
`define GPOSEQ_BIT_ENABLE_PIN_PULLDOWN 2
`define GPOSEQ_BIT_THERMAL_THRESHOLD 1
`define GPOSEQ_BIT_SPREAD_SPECTRUM 0

// ****************************************************************
// timing
// ****************************************************************
`define GPOSEQ_CLK_PERIOD_NS 50
`define GPOSEQ_HALF_MS_NS 500000
// half a millisecond of 50 ns clock periods, sized to the prescaler
`define GPOSEQ_TICK_CYCLES 14'h2710

// ****************************************************************
// serial port
// ****************************************************************
`define GPOSEQ_DEV_ADDR 7'h2A

`endif

/* File: logic/gposeq_delay.v */
// edge delay timer for the second general output
`timescale 1ns/1ns
`default_nettype none
`include "gposeq_defs.vh"

module gposeq_delay #(
	parameter [13:0] TICK_CYCLES = `GPOSEQ_TICK_CYCLES
) (
	input wire ref_clk,
	input wire reset_n,
	input wire enable_level,
	input wire [3:0] on_code,
	input wire [3:0] off_code,
	input wire on_range,
	input wire off_range,
	output reg delayed_level
);

	reg enable_prev_reg;
	reg target_reg;
	reg [13:0] prescale_reg;
	reg [4:0] remain_reg;
	wire [3:0] code;
	wire range;
	wire [4:0] units;

	assign code = enable_level ? on_code : off_code;
	assign range = enable_level ? on_range : off_range;
	// step is half a millisecond; the long range doubles the count
	assign units = range ? {code, 1'b0} : {1'b0, code};

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			enable_prev_reg <= 1'b0;
			target_reg <= 1'b0;
			prescale_reg <= 14'h0000;
			remain_reg <= 5'h00;
			delayed_level <= 1'b0;
		end else begin
			enable_prev_reg <= enable_level;
			if (enable_level != enable_prev_reg) begin
				// a new edge restarts the count from zero
				target_reg <= enable_level;
				prescale_reg <= 14'h0000;
				if (code == 4'h0) begin
					delayed_level <= enable_level;
					remain_reg <= 5'h00;
				end else begin
					remain_reg <= units;
				end
			end else if (remain_reg != 5'h00) begin
				if (prescale_reg == TICK_CYCLES - 14'h0001) begin
					prescale_reg <= 14'h0000;
					remain_reg <= remain_reg - 5'h01;
					if (remain_reg == 5'h01) begin
						delayed_level <= target_reg;
					end
				end else begin
					prescale_reg <= prescale_reg + 14'h0001;
				end
			end
		end
	end

endmodule
`default_nettype wire

/* File: dv/gposeq_host.sv */
// serial bus host and enable pin driver facing the general output block
`timescale 1ns/1ns
`default_nettype none

module gposeq_host #(
	parameter logic [6:0] DEV_ADDR = 7'h00
) (
	input wire logic ref_clk,
	input wire logic sda_oe,
	output logic scl_in,
	output wire logic sda_in,
	output logic enable_pin
);
	logic sda_drv;
	// ****************************************************************
	// open-drain data wire with pull-up
	// ****************************************************************
	assign sda_in = sda_drv & ~sda_oe;
	initial begin
		scl_in = 1'b1;
		sda_drv = 1'b1;
		enable_pin = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic set_enable(input logic v);
		@(posedge ref_clk);
		enable_pin <= v;
	endtask
	// long low phase keeps the device's synced fall well before the next rise
	task automatic bit_io(input logic b, output logic r);
		sda_drv <= b;
		wt(8);
		scl_in <= 1'b1;
		wt(8);
		r = sda_in;
		scl_in <= 1'b0;
		wt(1);
	endtask
	// serves as start and repeated start
	task automatic start();
		sda_drv <= 1'b1;
		wt(8);
		scl_in <= 1'b1;
		wt(8);
		sda_drv <= 1'b0;
		wt(8);
		scl_in <= 1'b0;
		wt(1);
	endtask
	task automatic stop();
		sda_drv <= 1'b0;
		wt(8);
		scl_in <= 1'b1;
		wt(8);
		sda_drv <= 1'b1;
		wt(8);
	endtask
	// ninth bit is always released: device ack on writes, host nack on reads
	task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r[i]);
		end
		bit_io(1'b1, ack);
	endtask
	task automatic write_reg(input logic [6:0] dv, input logic [7:0] a, input logic [7:0] d,
		output logic ok);
		logic [7:0] r;
		logic k0, k1, k2;
		start();
		xfer({dv, 1'b0}, r, k0);
		xfer(a, r, k1);
		xfer(d, r, k2);
		stop();
		ok = ~(k0 | k1 | k2);
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] r;
		logic k;
		start();
		xfer({DEV_ADDR, 1'b0}, r, k);
		xfer(a, r, k);
		start();
		xfer({DEV_ADDR, 1'b1}, r, k);
		xfer(8'hFF, d, k);
		stop();
	endtask
endmodule

`default_nettype wire

/* File: dv/gposeq_checker.sv */
// port checker for the general output sequencing block
`timescale 1ns/1ns
`default_nettype none

module gposeq_checker #(
	parameter [13:0] TICK_CYCLES = 14'h2710,
	parameter [6:0] DEV_ADDR = 7'h2A
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic enable_pin,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic first_general_output_out,
	input wire logic first_general_output_oe,
	input wire logic second_general_output_out,
	input wire logic second_general_output_oe,
	input wire logic external_clock_pin_select,
	input wire logic clock_pin_pulldown,
	input wire logic enable_pin_pulldown,
	input wire logic thermal_warning_threshold,
	input wire logic spread_spectrum_enable
);
	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	AST_RESET_QUIET: assert property (disable iff (1'b0) !reset_n |->
		!first_general_output_out && !second_general_output_out && !sda_oe)
		else $error("outputs active during reset");
	AST_FIRST_DRIVE: assert property (first_general_output_out |-> first_general_output_oe)
		else $error("first output high without push-pull drive");
	AST_SECOND_DRIVE: assert property (!external_clock_pin_select &&
		second_general_output_out |-> second_general_output_oe)
		else $error("second output high without push-pull drive");
	AST_CLOCK_INPUT: assert property (external_clock_pin_select[*3] |-> !second_general_output_oe)
		else $error("clock pin driven while selected as clock input");
	AST_SDA_LOW_ONLY: assert property (sda_out == 1'b0)
		else $error("data line driven high");
	AST_SDA_SETTLED: assert property (scl_in[*3] |-> $stable(sda_oe))
		else $error("data line changed while serial clock high");
	AST_FIRST_QUIET: assert property (($stable(enable_pin) && scl_in)[*6] |->
		$stable(first_general_output_out))
		else $error("first output changed without cause");
	AST_CFG_SCL_LOW: assert property ($changed({external_clock_pin_select,
		clock_pin_pulldown, enable_pin_pulldown, thermal_warning_threshold,
		spread_spectrum_enable}) |-> !scl_in)
		else $error("configuration changed outside a data byte end");
	cover property ($rose(second_general_output_out));
	cover property ($rose(sda_oe));
	cover property ($rose(external_clock_pin_select));
endmodule

bind gposeq_top gposeq_checker #(.TICK_CYCLES(TICK_CYCLES), .DEV_ADDR(DEV_ADDR)) i_chk (
	.ref_clk(ref_clk), .reset_n(reset_n), .enable_pin(enable_pin), .scl_in(scl_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .first_general_output_out(first_general_output_out),
	.first_general_output_oe(first_general_output_oe),
	.second_general_output_out(second_general_output_out),
	.second_general_output_oe(second_general_output_oe),
	.external_clock_pin_select(external_clock_pin_select),
	.clock_pin_pulldown(clock_pin_pulldown), .enable_pin_pulldown(enable_pin_pulldown),
	.thermal_warning_threshold(thermal_warning_threshold),
	.spread_spectrum_enable(spread_spectrum_enable));

`default_nettype wire

/* File: dv/tb_gpo_sequencing_config.sv */
// testbench for the general output sequencing block
`timescale 1ns/1ns
`default_nettype none
`include "gposeq_defs.vh"

module tb_gpo_sequencing_config;
	localparam int TICK = 10;
	logic ref_clk, reset_n;
	wire logic enable_pin, scl_in, sda_in, sda_out, sda_oe;
	wire logic fo, foe, so, soe, ext, cpd, epd, thr, ss;
	int fails = 0;
	int n_tests = 0;
	int n;
	logic [7:0] rd;
	logic ok;
	logic [7:0] dly [4] = '{8'h32, 8'hFF, 8'h5F, 8'h00};
	logic [7:0] cfg [4] = '{8'h00, 8'h60, 8'h40, 8'h20};
	gposeq_top #(.TICK_CYCLES(14'h000A)) i_gposeq_top (.ref_clk(ref_clk), .reset_n(reset_n),
		.enable_pin(enable_pin), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
		.sda_oe(sda_oe), .first_general_output_out(fo), .first_general_output_oe(foe),
		.second_general_output_out(so), .second_general_output_oe(soe),
		.external_clock_pin_select(ext), .clock_pin_pulldown(cpd),
		.enable_pin_pulldown(epd), .thermal_warning_threshold(thr),
		.spread_spectrum_enable(ss));
	gposeq_host #(.DEV_ADDR(`GPOSEQ_DEV_ADDR)) i_host (.ref_clk(ref_clk), .sda_oe(sda_oe),
		.scl_in(scl_in), .sda_in(sda_in), .enable_pin(enable_pin));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_host.write_reg(`GPOSEQ_DEV_ADDR, a, d, ok);
		check({7'h00, ok}, 8'h01);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		i_host.read_reg(a, rd);
		check(rd, exp);
	endtask
	// two-byte write, then two-byte read with host acknowledge: pointer steps per byte
	task automatic burst(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
		logic [7:0] r0, r1;
		logic k0, k1, k2, k3, k4;
		i_host.start();
		i_host.xfer({`GPOSEQ_DEV_ADDR, 1'b0}, r0, k0);
		i_host.xfer(a, r0, k1);
		i_host.xfer(d0, r0, k2);
		i_host.xfer(d1, r0, k3);
		i_host.stop();
		check({7'h00, ~(k0 | k1 | k2 | k3)}, 8'h01);
		i_host.start();
		i_host.xfer({`GPOSEQ_DEV_ADDR, 1'b0}, r0, k0);
		i_host.xfer(a, r0, k1);
		i_host.start();
		i_host.xfer({`GPOSEQ_DEV_ADDR, 1'b1}, r0, k2);
		for (int i = 7; i >= 0; i--) begin
			i_host.bit_io(1'b1, r0[i]);
		end
		i_host.bit_io(1'b0, k3);
		i_host.xfer(8'hFF, r1, k4);
		i_host.stop();
		check(r0, d0);
		check(r1, d1);
	endtask
	// returns {out, oe}; open drain pulls low by enabling the driver
	function automatic logic [1:0] drv(input logic [2:0] c, input logic en);
		logic lvl;
		lvl = c[0] & (en | ~c[1]);
		return c[2] ? {1'b0, ~lvl} : {lvl, 1'b1};
	endfunction
	// window allows for the enable synchroniser and the output register
	task automatic meas(input logic v, input int exp);
		n = 0;
		i_host.set_enable(v);
		while (so !== v && n < 1000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check({7'h00, (n >= exp + 2 && n <= exp + 7)}, 8'h01);
	endtask
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		reset_n = 1'b0;
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		#1;
		check({6'h00, fo, foe}, 8'h01);
		rdchk(8'h11, `GPOSEQ_RST_SECOND_OUTPUT_DELAY);
		rdchk(8'h12, `GPOSEQ_RST_OUTPUT_CONTROL);
		rdchk(8'h13, `GPOSEQ_RST_DEVICE_CONFIG);
		wr(8'h12, 8'hFF);
		rdchk(8'h12, 8'h77);
		rdchk(8'h20, 8'h00);
		i_host.write_reg(`GPOSEQ_DEV_ADDR ^ 7'h01, 8'h12, 8'h00, ok);
		check({7'h00, ok}, 8'h00);
		rdchk(8'h12, 8'h77);
		wr(8'h13, 8'h8F);
		rdchk(8'h13, 8'h8F);
		burst(8'h12, 8'h44, 8'h9E);
		for (int b = 0; b < 5; b++) begin
			wr(8'h13, 8'h01 << b);
			@(posedge ref_clk);
			#1;
			check({3'h0, ext, cpd, epd, thr, ss}, 8'h01 << b);
		end
		check({7'h00, soe}, 8'h00);
		wr(8'h13, 8'h00);
		for (int e = 0; e < 2; e++) begin
			i_host.set_enable(e[0]);
			for (int c = 0; c < 8; c++) begin
				wr(8'h12, {1'b0, c[2:0], 1'b0, c[2:0]});
				repeat (4) @(posedge ref_clk);
				#1;
				check({6'h00, fo, foe}, {6'h00, drv(c[2:0], e[0])});
				check({6'h00, so, soe}, {6'h00, drv(c[2:0], e[0])});
			end
		end
		i_host.set_enable(1'b0);
		wr(8'h12, 8'h30);
		for (int k = 0; k < 4; k++) begin
			wr(8'h11, dly[k]);
			wr(8'h13, cfg[k]);
			rdchk(8'h11, dly[k]);
			meas(1'b1, dly[k][3:0] * (cfg[k][6] ? 2 : 1) * TICK);
			meas(1'b0, dly[k][7:4] * (cfg[k][5] ? 2 : 1) * TICK);
		end
		wr(8'h11, 8'h44);
		wr(8'h13, 8'h00);
		i_host.set_enable(1'b1);
		repeat (20) @(posedge ref_clk);
		i_host.set_enable(1'b0);
		n = 0;
		repeat (80) begin
			@(posedge ref_clk);
			#1;
			n += int'(so !== 1'b0);
		end
		check(n[7:0], 8'h00);
		report_and_stop();
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		fails++;
		report_and_stop();
	end
endmodule

`default_nettype wire
